// file: rtl/isl_pkg.sv
package isl_pkg;

   localparam int ISL_ADDR_W = 12;
   localparam int ISL_DATA_W = 8;
   localparam int ISL_LANES = 4;

   // Register offsets
   localparam logic [ISL_ADDR_W-1:0] ISL_ENABLE0_OFF = 12'h01f;
   localparam logic [ISL_ADDR_W-1:0] ISL_ENABLE1_OFF = 12'h020;
   localparam logic [ISL_ADDR_W-1:0] ISL_STATUS0_OFF = 12'h023;
   localparam logic [ISL_ADDR_W-1:0] ISL_STATUS1_OFF = 12'h024;
   localparam logic [ISL_ADDR_W-1:0] ISL_LANE_FULL_OFF = 12'h30c;
   localparam logic [ISL_ADDR_W-1:0] ISL_LANE_EMPTY_OFF = 12'h30d;

   // Bit positions in the 16-bit view {status1, status0}
   localparam int ISL_BIT_CONV_LOSS = 7;
   localparam int ISL_BIT_CONV_LOCKED = 6;
   localparam int ISL_BIT_LINK_LOSS = 4;
   localparam int ISL_BIT_LINK_LOCKED = 3;
   localparam int ISL_BIT_LANE_FAULT = 1;
   localparam int ISL_BIT_DELAY_LINE_FAULT = 0;
   localparam int ISL_BIT_BAD_PARAM = 15;
   localparam int ISL_BIT_LANE_LEVEL = 14;
   localparam int ISL_BIT_DELAY_LEVEL = 13;

   // Implemented bits; every other bit reads zero and ignores writes
   localparam logic [15:0] ISL_VALID_MASK = 16'he0db;
   localparam logic [ISL_DATA_W-1:0] ISL_RESET_VAL = 8'h00;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ISL_ADDR_W-1:0] addr;
      logic [ISL_DATA_W-1:0] data;
   } isl_reg_req_t;

endpackage

// file: rtl/isl_status_cell.sv
`timescale 1ns/10ps
module isl_status_cell
   import isl_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Source and control
   input wire logic cond,
   input wire logic irqEnable,
   input wire logic clearReq,
   // Results
   output logic statusView,
   output logic pending
);

   logic condPrev_reg;
   logic condPrev_next;
   logic latch_reg;
   logic latch_next;
   logic risePulse;

   always_comb begin
      risePulse = cond & ~condPrev_reg;
      condPrev_next = cond;
      if (!irqEnable) begin
         // Live mode keeps nothing, so enabling later needs a fresh edge
         latch_next = 1'b0;
      end else if (risePulse) begin
         // An edge in the clearing cycle keeps the bit set
         latch_next = 1'b1;
      end else if (clearReq) begin
         latch_next = 1'b0;
      end else begin
         latch_next = latch_reg;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         condPrev_reg <= 1'b0;
         latch_reg <= 1'b0;
      end else begin
         condPrev_reg <= condPrev_next;
         latch_reg <= latch_next;
      end
   end

   assign statusView = irqEnable ? latch_reg : cond;
   assign pending = irqEnable & latch_reg;

endmodule

// file: rtl/isl_irq_status_latch.sv
`timescale 1ns/10ps
// What this block does
// - With its enable low, a status bit shows the live source condition and raises no interrupt.
// - With its enable high, a status bit latches on a rising source edge and pulls the interrupt low.
// - Writing one to a latched bit clears it unless a new source edge arrives in that cycle, and the interrupt releases when no enabled bit is set.
// - Bit 7 of the first status register reports loss of converter clock lock.
// - Bit 6 of the first status register reports converter clock locked.
// - Bit 4 of the first status register reports loss of link clock lock.
// - Bit 3 of the first status register reports link clock locked.
// - Bit 1 of the first status register flags any lane buffer going full or empty while the link is enabled.
// - The lane buffer fault stays until software disables and re-enables the link.
// - Per-lane full flags read at 0x30C and per-lane empty flags at 0x30D.
// - Bit 0 of the first status register flags a delay-line buffer error.
// - Bit 7 of the second status register flags a bad link parameter.
// - Bit 6 of the second status register reports lane buffer level, live or latched.
// - Bit 5 of the second status register reports delay buffer level, live or latched.
// - Each source has its own read-write enable bit, reset to zero, choosing live or latched.
module isl_irq_status_latch
   import isl_pkg::*;
#(
   parameter int LANES = ISL_LANES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Register port
   input wire isl_reg_req_t regReq,
   output logic [ISL_DATA_W-1:0] regRdata,
   // Event sources
   input wire logic convClockLockLoss,
   input wire logic convClockLocked,
   input wire logic linkClockLockLoss,
   input wire logic linkClockLocked,
   input wire logic delayLineBufferFault,
   input wire logic badLinkParameter,
   input wire logic laneBufferLevelFlag,
   input wire logic delayBufferLevelFlag,
   // Link lane buffers
   input wire logic linkEnable,
   input wire logic [LANES-1:0] laneBufFull,
   input wire logic [LANES-1:0] laneBufEmpty,
   // Shared interrupt
   output logic irqOutN
);

   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] enable0_reg;
   logic [7:0] enable0_next;
   logic [7:0] enable1_reg;
   logic [7:0] enable1_next;
   logic laneFaultHold_reg;
   logic laneFaultHold_next;
   logic [ISL_DATA_W-1:0] rdata_reg;
   logic [ISL_DATA_W-1:0] rdata_next;
   logic irqN_reg;
   logic irqN_next;
   logic [15:0] srcCond;
   logic [15:0] enAll;
   logic [15:0] clearAll;
   logic [15:0] statusView;
   logic [15:0] pending;

   function automatic logic hit(input isl_reg_req_t req, input logic [ISL_ADDR_W-1:0] off);
      hit = req.addr == off;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Lane fault hold
   always_comb begin
      laneFaultHold_next = linkEnable & (laneFaultHold_reg | (|(laneBufFull | laneBufEmpty)));
   end

   always_comb begin
      srcCond = 16'h0000;
      srcCond[ISL_BIT_CONV_LOSS] = convClockLockLoss;
      srcCond[ISL_BIT_CONV_LOCKED] = convClockLocked;
      srcCond[ISL_BIT_LINK_LOSS] = linkClockLockLoss;
      srcCond[ISL_BIT_LINK_LOCKED] = linkClockLocked;
      srcCond[ISL_BIT_LANE_FAULT] = laneFaultHold_reg;
      srcCond[ISL_BIT_DELAY_LINE_FAULT] = delayLineBufferFault;
      srcCond[ISL_BIT_BAD_PARAM] = badLinkParameter;
      srcCond[ISL_BIT_LANE_LEVEL] = laneBufferLevelFlag;
      srcCond[ISL_BIT_DELAY_LEVEL] = delayBufferLevelFlag;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enables and clears
   always_comb begin
      enable0_next = enable0_reg;
      enable1_next = enable1_reg;
      if (regReq.wr && hit(regReq, ISL_ENABLE0_OFF)) begin
         enable0_next = regReq.data & ISL_VALID_MASK[7:0];
      end
      if (regReq.wr && hit(regReq, ISL_ENABLE1_OFF)) begin
         enable1_next = regReq.data & ISL_VALID_MASK[15:8];
      end
   end

   assign enAll = {enable1_reg, enable0_reg};

   always_comb begin
      clearAll = 16'h0000;
      if (regReq.wr && hit(regReq, ISL_STATUS0_OFF)) begin
         clearAll[7:0] = regReq.data;
      end
      if (regReq.wr && hit(regReq, ISL_STATUS1_OFF)) begin
         clearAll[15:8] = regReq.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status cells
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_bit
         if (ISL_VALID_MASK[gi]) begin : g_cell
            isl_status_cell u_cell (
               .clk_sys(clk_sys),
               .srst(srst),
               .cond(srcCond[gi]),
               .irqEnable(enAll[gi]),
               .clearReq(clearAll[gi]),
               .statusView(statusView[gi]),
               .pending(pending[gi])
            );
         end else begin : g_none
            assign statusView[gi] = 1'b0;
            assign pending[gi] = 1'b0;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Read path and interrupt
   always_comb begin
      rdata_next = ISL_RESET_VAL;
      if (regReq.rd) begin
         if (hit(regReq, ISL_ENABLE0_OFF)) begin
            rdata_next = enable0_reg;
         end else if (hit(regReq, ISL_ENABLE1_OFF)) begin
            rdata_next = enable1_reg;
         end else if (hit(regReq, ISL_STATUS0_OFF)) begin
            rdata_next = statusView[7:0];
         end else if (hit(regReq, ISL_STATUS1_OFF)) begin
            rdata_next = statusView[15:8];
         end else if (hit(regReq, ISL_LANE_FULL_OFF)) begin
            rdata_next = ISL_DATA_W'(laneBufFull);
         end else if (hit(regReq, ISL_LANE_EMPTY_OFF)) begin
            rdata_next = ISL_DATA_W'(laneBufEmpty);
         end
      end
      irqN_next = ~(|pending);
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         enable0_reg <= ISL_RESET_VAL;
         enable1_reg <= ISL_RESET_VAL;
         laneFaultHold_reg <= 1'b0;
         rdata_reg <= ISL_RESET_VAL;
         irqN_reg <= 1'b1;
      end else begin
         enable0_reg <= enable0_next;
         enable1_reg <= enable1_next;
         laneFaultHold_reg <= laneFaultHold_next;
         rdata_reg <= rdata_next;
         irqN_reg <= irqN_next;
      end
   end

   assign regRdata = rdata_reg;
   assign irqOutN = irqN_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   logic status0Clear;
   assign status0Clear = regReq.wr && hit(regReq, ISL_STATUS0_OFF);

   live_follow_a: assert property (
      (((~enAll) & ISL_VALID_MASK) & (statusView ^ srcCond)) == 16'h0000
   ) else $error("Live status bit differs from its source");

   latch_on_edge_a: assert property (
      (enAll[7] && $rose(srcCond[7])) ##1 enAll[7] |-> statusView[7] ##1 !irqOutN
   ) else $error("Enabled edge did not latch or raise interrupt");

   clear_bit_a: assert property (
      enAll[6] && status0Clear && regReq.data[6] && !$rose(srcCond[6])
      |=> !statusView[6]
   ) else $error("Write of one did not clear latched bit");

   irq_release_a: assert property (
      !(|pending) |=> irqOutN
   ) else $error("Interrupt held with nothing pending");

   status_read_a: assert property (
      regReq.rd && hit(regReq, ISL_STATUS0_OFF) |=> regRdata == $past(statusView[7:0])
   ) else $error("First status register read mismatch");

   lane_fault_set_a: assert property (
      linkEnable && (|(laneBufFull | laneBufEmpty)) |=> laneFaultHold_reg
   ) else $error("Lane buffer fault not raised");

   lane_fault_keep_a: assert property (
      laneFaultHold_reg && linkEnable |=> laneFaultHold_reg
   ) else $error("Lane buffer fault dropped while link enabled");

   lane_full_read_a: assert property (
      regReq.rd && hit(regReq, ISL_LANE_FULL_OFF) |=> regRdata == ISL_DATA_W'($past(laneBufFull))
   ) else $error("Lane full flags read mismatch");

   // Register port never issues a write and a read back to back, so watch the register itself
   enable_write_a: assert property (
      regReq.wr && hit(regReq, ISL_ENABLE1_OFF)
      |=> enable1_reg == ($past(regReq.data) & ISL_VALID_MASK[15:8])
   ) else $error("Enable register did not store write");

   reserved_zero_a: assert property (
      regReq.rd && hit(regReq, ISL_STATUS0_OFF) |=> !regRdata[5] && !regRdata[2]
   ) else $error("Reserved status bit read non-zero");

   set_wins_a: assert property (
      enAll[7] && $rose(srcCond[7]) && status0Clear && regReq.data[7] |=> statusView[7]
   ) else $error("Clear beat a simultaneous edge");

   write_zero_a: assert property (
      enAll[0] && statusView[0] && status0Clear && !regReq.data[0] |=> statusView[0]
   ) else $error("Write of zero changed a latched bit");

   irq_raised_c: cover property (!irqOutN);
   latch_cleared_c: cover property (pending[7] ##1 status0Clear ##1 !pending[7]);
   lane_fault_c: cover property (laneFaultHold_reg ##1 !linkEnable ##1 !laneFaultHold_reg);
   live_mode_c: cover property (!enAll[13] && $rose(srcCond[13]));

endmodule

// file: sim/isl_irq_status_latch_tb.sv
`timescale 1ns/10ps
module isl_irq_status_latch_tb
   import isl_pkg::*;
();
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   isl_reg_req_t regReq = '0;
   logic [ISL_DATA_W-1:0] regRdata;
   logic [7:0] src = 8'h00;
   logic linkEnable = 1'b0;
   logic [3:0] laneBufFull = 4'h0;
   logic [3:0] laneBufEmpty = 4'h0;
   logic irqOutN;
   int num_errors = 0;
   int n_compared = 0;
   // Bit of each source in the {status1, status0} view
   int srcPos [8] = '{ISL_BIT_CONV_LOSS, ISL_BIT_CONV_LOCKED, ISL_BIT_LINK_LOSS,
      ISL_BIT_LINK_LOCKED, ISL_BIT_DELAY_LINE_FAULT, ISL_BIT_BAD_PARAM,
      ISL_BIT_LANE_LEVEL, ISL_BIT_DELAY_LEVEL};

   always #25 clk_sys = ~clk_sys;

   isl_irq_status_latch #(.LANES(4)) i_dut (
      .clk_sys(clk_sys), .srst(srst), .regReq(regReq), .regRdata(regRdata),
      .convClockLockLoss(src[0]), .convClockLocked(src[1]), .linkClockLockLoss(src[2]),
      .linkClockLocked(src[3]), .delayLineBufferFault(src[4]), .badLinkParameter(src[5]),
      .laneBufferLevelFlag(src[6]), .delayBufferLevelFlag(src[7]),
      .linkEnable(linkEnable), .laneBufFull(laneBufFull), .laneBufEmpty(laneBufEmpty),
      .irqOutN(irqOutN));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Request held across exactly one rising edge; data sampled a cycle later
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk_sys);
      regReq.wr = w;
      regReq.rd = ~w;
      regReq.addr = a;
      regReq.data = d;
      @(negedge clk_sys);
      regReq = '0;
      q = regRdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask

   task automatic rdst(output logic [15:0] s);
      acc(1'b0, ISL_STATUS0_OFF, 8'h00, s[7:0]);
      acc(1'b0, ISL_STATUS1_OFF, 8'h00, s[15:8]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      logic [11:0] offs [6] = '{ISL_ENABLE0_OFF, ISL_ENABLE1_OFF, ISL_STATUS0_OFF,
         ISL_STATUS1_OFF, ISL_LANE_FULL_OFF, ISL_LANE_EMPTY_OFF};
      logic [7:0] q;
      chk("irq after reset", {15'h0, irqOutN}, 16'h0001);
      foreach (offs[k]) begin
         acc(1'b0, offs[k], 8'h00, q);
         chk("reset value", {8'h00, q}, 16'h0000);
      end
      $display("test_reset done");
   endtask

   task automatic test_live();
      logic [15:0] s;
      logic [7:0] q;
      for (int i = 0; i < 8; i++) begin
         src = 8'(1 << i);
         rdst(s);
         chk("live status", s, 16'(1 << srcPos[i]));
         chk("live irq", {15'h0, irqOutN}, 16'h0001);
      end
      // All eight src sources high at once, lane fault low, exposes any reserved bit that leaks
      src = 8'hff;
      wr(ISL_STATUS0_OFF, 8'h24);
      rdst(s);
      chk("all live", s, 16'he0d9);
      acc(1'b0, 12'h100, 8'h00, q);
      chk("unmapped", {8'h00, q}, 16'h0000);
      src = 8'h00;
      rdst(s);
      chk("live idle", s, 16'h0000);
      $display("test_live done");
   endtask

   task automatic test_latched();
      logic [15:0] s;
      logic [7:0] q;
      logic [11:0] a;
      logic [7:0] m;
      wr(ISL_ENABLE0_OFF, 8'hff);
      wr(ISL_ENABLE1_OFF, 8'hff);
      acc(1'b0, ISL_ENABLE0_OFF, 8'h00, q);
      chk("enable0", {8'h00, q}, 16'h00db);
      acc(1'b0, ISL_ENABLE1_OFF, 8'h00, q);
      chk("enable1", {8'h00, q}, 16'h00e0);
      for (int i = 0; i < 8; i++) begin
         a = (srcPos[i] > 7) ? ISL_STATUS1_OFF : ISL_STATUS0_OFF;
         m = 8'(1 << (srcPos[i] % 8));
         @(negedge clk_sys);
         src[i] = 1'b1;
         @(negedge clk_sys);
         src[i] = 1'b0;
         rdst(s);
         chk("latched", s, 16'(1 << srcPos[i]));
         chk("irq low", {15'h0, irqOutN}, 16'h0000);
         wr(a, 8'h00);
         rdst(s);
         chk("write zero", s, 16'(1 << srcPos[i]));
         // New edge in the very cycle of the clear
         @(negedge clk_sys);
         regReq.wr = 1'b1;
         regReq.addr = a;
         regReq.data = m;
         src[i] = 1'b1;
         @(negedge clk_sys);
         regReq = '0;
         src[i] = 1'b0;
         rdst(s);
         chk("set beats clear", s, 16'(1 << srcPos[i]));
         wr(a, m);
         @(negedge clk_sys);
         chk("irq released", {15'h0, irqOutN}, 16'h0001);
         rdst(s);
         chk("cleared", s, 16'h0000);
      end
      wr(ISL_ENABLE0_OFF, 8'h00);
      wr(ISL_ENABLE1_OFF, 8'h00);
      $display("test_latched done");
   endtask

   task automatic test_lane();
      logic [15:0] s;
      logic [7:0] q;
      @(negedge clk_sys);
      linkEnable = 1'b1;
      @(negedge clk_sys);
      laneBufFull = 4'h4;
      laneBufEmpty = 4'h1;
      acc(1'b0, ISL_LANE_FULL_OFF, 8'h00, q);
      chk("lane full", {8'h00, q}, 16'h0004);
      acc(1'b0, ISL_LANE_EMPTY_OFF, 8'h00, q);
      chk("lane empty", {8'h00, q}, 16'h0001);
      laneBufFull = 4'h0;
      laneBufEmpty = 4'h0;
      rdst(s);
      chk("lane fault held", s, 16'h0002);
      chk("lane irq", {15'h0, irqOutN}, 16'h0001);
      @(negedge clk_sys);
      linkEnable = 1'b0;
      @(negedge clk_sys);
      linkEnable = 1'b1;
      rdst(s);
      chk("lane fault gone", s, 16'h0000);
      // Latched mode: a fresh lane fault edge must latch and pull the interrupt
      wr(ISL_ENABLE0_OFF, 8'h02);
      @(negedge clk_sys);
      laneBufEmpty = 4'h1;
      @(negedge clk_sys);
      laneBufEmpty = 4'h0;
      rdst(s);
      chk("lane fault latched", s, 16'h0002);
      chk("lane fault irq", {15'h0, irqOutN}, 16'h0000);
      wr(ISL_STATUS0_OFF, 8'h02);
      @(negedge clk_sys);
      chk("lane irq released", {15'h0, irqOutN}, 16'h0001);
      rdst(s);
      chk("lane latch cleared", s, 16'h0000);
      // Clearing the latch leaves the underlying fault until the link restarts
      wr(ISL_ENABLE0_OFF, 8'h00);
      rdst(s);
      chk("lane fault persists", s, 16'h0002);
      @(negedge clk_sys);
      linkEnable = 1'b0;
      @(negedge clk_sys);
      linkEnable = 1'b1;
      rdst(s);
      chk("lane fault removed", s, 16'h0000);
      $display("test_lane done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end

   initial begin
      repeat (5) @(negedge clk_sys);
      srst = 1'b0;
      test_reset();
      test_live();
      test_latched();
      test_lane();
      print_verdict();
   end
endmodule
